// ### pkg/port_xbar_pkg.sv
// Purpose: constants and carriers for the port crossbar and external interrupt config block
// Assumes: special function register bus with register pages, one system clock
// Notes: the port 3 width option stands in the top module as a parameter
//
// Functional notes
// - second irq polarity bit7: 0 low, 1 high
// - bits 6:4 pick port1 pin for second irq
// - first irq polarity bit3: 0 low, 1 high
// - bits 2:0 pick port1 pin for first irq
// - irq watches pin independent of crossbar routing
// - skipped pins never handed to a peripheral
// - bit7 low enables pullups except analog pins
// - bit6 enables crossbar pin routing
// - bit0 routes LIN transmit and receive pins, only while bit6 is also set
// - skip mask bit n skips port2 pin n
// - port3 write sets latch, read returns pins
// - port3 register on every page, bit addressable
// - small package implements port3 bit 0 only
package port_xbar_pkg;

    // =====================================================
    // register map
    localparam logic [7:0] ADDR_PORT3_DATA = 8'hB0;
    localparam logic [7:0] ADDR_XBAR_CTRL2 = 8'hC7;
    localparam logic [7:0] ADDR_P2_SKIP = 8'hD6;
    localparam logic [7:0] ADDR_EXT_IRQ_CFG = 8'hE4;
    localparam logic [7:0] CFG_PAGE = 8'h0F;

    // =====================================================
    // reset values
    localparam logic [7:0] RST_PORT3_DATA = 8'hFF;
    localparam logic [7:0] RST_XBAR_CTRL2 = 8'h00;
    localparam logic [7:0] RST_P2_SKIP = 8'h00;
    localparam logic [7:0] RST_EXT_IRQ_CFG = 8'h00;

    // =====================================================
    // field positions
    localparam int unsigned IRQ_B_POL_BIT = 7;
    localparam int unsigned IRQ_B_SEL_LSB = 4;
    localparam int unsigned IRQ_A_POL_BIT = 3;
    localparam int unsigned IRQ_A_SEL_LSB = 0;
    localparam int unsigned WEAK_PUD_BIT = 7;
    localparam int unsigned XBAR_EN_BIT = 6;
    localparam int unsigned LIN_ROUTE_BIT = 0;

    // =====================================================
    // carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] page;
        logic wr;
        logic rd;
        logic bit_wr;
        logic [2:0] bit_idx;
        logic bit_val;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic ext_irq_b_polarity;
        logic [2:0] ext_irq_b_pin_select;
        logic ext_irq_a_polarity;
        logic [2:0] ext_irq_a_pin_select;
        logic weak_pullup_disable;
        logic crossbar_enable;
        logic lin_pin_route_enable;
        logic [7:0] port2_skip_mask;
        logic [7:0] port3_data;
    } port_cfg_t;

endpackage

// ### hdl/ext_irq_sync.sv
// Purpose: pin select, two-flop synchroniser and polarity for one external interrupt
// Assumes: pins may change at any time relative to the system clock
// Notes: output lags the pin by three clock-enabled edges
`timescale 1ns/1ps
`default_nettype none
module ext_irq_sync (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // selection
    input wire logic [7:0] i_pins,
    input wire logic [2:0] i_sel,
    input wire logic i_active_high,
    // request
    output logic o_req_q
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic req_d;

    // =====================================================
    // next values; the first flop feeds only the second
    always_comb begin
        meta_d = meta_q;
        sync_d = sync_q;
        req_d = o_req_q;
        if (i_ce) begin
            meta_d = i_pins[i_sel];
            sync_d = meta_q;
            req_d = sync_q ~^ i_active_high;
        end
    end

    // reset to idle: no request
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            o_req_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            o_req_q <= req_d;
        end
    end
endmodule
`default_nettype wire

// ### hdl/port_crossbar_ext_int_config.sv
// Purpose: port crossbar controls, port 2 skip mask, port 3 data and external irq routing
// Assumes: register bus inputs synchronous to i_clk_sys; one access per cycle
// Notes: all outputs registered; effects show one edge after their cause, the interrupt requests three edges after the pin
`timescale 1ns/1ps
`default_nettype none
module port_crossbar_ext_int_config #(
    parameter bit P3_FULL = 1'b1 // 1: large package, all eight port 3 bits
) (
    // clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // register bus
    input wire port_xbar_pkg::sfr_req_t i_sfr,
    output logic [7:0] o_sfr_rdata,
    // port 1 pins watched by the interrupts
    input wire logic [7:0] i_p1_pin,
    output logic o_ext_irq_a,
    output logic o_ext_irq_b,
    // port 2 crossbar assignment
    output logic [7:0] o_p2_xbar_grant,
    // port 3 pins
    input wire logic [7:0] i_p3_pin,
    input wire logic [7:0] i_p3_analog,
    output logic [7:0] o_p3_out,
    output logic [7:0] o_p3_oe_b,
    output logic [7:0] o_p3_pullup_en,
    // LIN routing
    input wire logic i_lin_tx,
    input wire logic i_lin_rx_pin,
    output logic o_lin_tx_pin,
    output logic o_lin_tx_oe_b,
    output logic o_lin_rx
);
    import port_xbar_pkg::*;

    // implemented port 3 bits
    localparam logic [7:0] P3_MASK = P3_FULL ? 8'hFF : 8'h01;

    port_cfg_t cfg_q, cfg_d;
    logic [7:0] rdata_d;
    logic [7:0] grant_d;
    logic [7:0] pullup_d;
    logic [7:0] oe_b_d;
    logic lin_route;
    logic lin_tx_oe_b_d;
    logic lin_tx_pin_d;
    logic lin_rx_d;
    logic sel_p3, sel_xbar, sel_skip, sel_irq;
    logic any_wr;

    // =====================================================
    // address decode
    // port 3 ignores the page, the config registers need page 0x0F
    always_comb begin
        sel_p3 = (i_sfr.addr == ADDR_PORT3_DATA);
        sel_xbar = (i_sfr.page == CFG_PAGE) && (i_sfr.addr == ADDR_XBAR_CTRL2);
        sel_skip = (i_sfr.page == CFG_PAGE) && (i_sfr.addr == ADDR_P2_SKIP);
        sel_irq = (i_sfr.page == CFG_PAGE) && (i_sfr.addr == ADDR_EXT_IRQ_CFG);
        any_wr = i_sfr.wr || i_sfr.bit_wr;
    end

    // =====================================================
    // register file next values
    // bit writes only reach port 3, the one bit-addressable register here
    always_comb begin
        cfg_d = cfg_q;
        if (i_ce && i_sfr.wr) begin
            if (sel_irq) begin
                cfg_d.ext_irq_b_polarity = i_sfr.wdata[IRQ_B_POL_BIT];
                cfg_d.ext_irq_b_pin_select = i_sfr.wdata[IRQ_B_SEL_LSB +: 3];
                cfg_d.ext_irq_a_polarity = i_sfr.wdata[IRQ_A_POL_BIT];
                cfg_d.ext_irq_a_pin_select = i_sfr.wdata[IRQ_A_SEL_LSB +: 3];
            end
            if (sel_xbar) begin
                cfg_d.weak_pullup_disable = i_sfr.wdata[WEAK_PUD_BIT];
                cfg_d.crossbar_enable = i_sfr.wdata[XBAR_EN_BIT];
                cfg_d.lin_pin_route_enable = i_sfr.wdata[LIN_ROUTE_BIT];
                // bits 5:1 hold nothing; software keeps them zero
            end
            if (sel_skip) begin
                cfg_d.port2_skip_mask = i_sfr.wdata;
            end
            if (sel_p3) begin
                cfg_d.port3_data = i_sfr.wdata & P3_MASK;
            end
        end else if (i_ce && i_sfr.bit_wr && sel_p3) begin
            cfg_d.port3_data[i_sfr.bit_idx] = i_sfr.bit_val & P3_MASK[i_sfr.bit_idx];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            cfg_q.ext_irq_b_polarity <= RST_EXT_IRQ_CFG[IRQ_B_POL_BIT];
            cfg_q.ext_irq_b_pin_select <= RST_EXT_IRQ_CFG[IRQ_B_SEL_LSB +: 3];
            cfg_q.ext_irq_a_polarity <= RST_EXT_IRQ_CFG[IRQ_A_POL_BIT];
            cfg_q.ext_irq_a_pin_select <= RST_EXT_IRQ_CFG[IRQ_A_SEL_LSB +: 3];
            cfg_q.weak_pullup_disable <= RST_XBAR_CTRL2[WEAK_PUD_BIT];
            cfg_q.crossbar_enable <= RST_XBAR_CTRL2[XBAR_EN_BIT];
            cfg_q.lin_pin_route_enable <= RST_XBAR_CTRL2[LIN_ROUTE_BIT];
            cfg_q.port2_skip_mask <= RST_P2_SKIP;
            cfg_q.port3_data <= RST_PORT3_DATA & P3_MASK;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // =====================================================
    // pin-facing next values, from the next register state
    // so a write and its effect land on the same edge; held while disabled
    always_comb begin
        grant_d = o_p2_xbar_grant;
        pullup_d = o_p3_pullup_en;
        oe_b_d = o_p3_oe_b;
        lin_tx_oe_b_d = o_lin_tx_oe_b;
        lin_tx_pin_d = o_lin_tx_pin;
        lin_rx_d = o_lin_rx;
        // LIN is a crossbar peripheral, so it also needs the crossbar on
        lin_route = cfg_d.crossbar_enable && cfg_d.lin_pin_route_enable;
        if (i_ce) begin
            // skipped pins are never offered to a peripheral
            grant_d = cfg_d.crossbar_enable ? ~cfg_d.port2_skip_mask : 8'h00;
            // analog pins never get a pullup
            pullup_d = cfg_d.weak_pullup_disable ? 8'h00 : (~i_p3_analog & P3_MASK);
            // digital pins drive their latch; analog and absent bits stay released
            oe_b_d = i_p3_analog | ~P3_MASK;
            lin_tx_oe_b_d = !lin_route;
            lin_tx_pin_d = lin_route ? i_lin_tx : 1'b1;
            // idle receive level is recessive high when unrouted
            lin_rx_d = lin_route ? i_lin_rx_pin : 1'b1;
        end
    end

    // =====================================================
    // read data, unmapped addresses answer zero
    always_comb begin
        rdata_d = o_sfr_rdata;
        if (i_ce && i_sfr.rd) begin
            unique case (1'b1)
                sel_p3: rdata_d = i_p3_pin & P3_MASK;
                sel_xbar: rdata_d = {cfg_q.weak_pullup_disable, cfg_q.crossbar_enable,
                                     5'b00000, cfg_q.lin_pin_route_enable};
                sel_skip: rdata_d = cfg_q.port2_skip_mask;
                sel_irq: rdata_d = {cfg_q.ext_irq_b_polarity, cfg_q.ext_irq_b_pin_select,
                                    cfg_q.ext_irq_a_polarity, cfg_q.ext_irq_a_pin_select};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // output flops only register; the enable is handled in the next-value logic
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_sfr_rdata <= 8'h00;
            o_p2_xbar_grant <= 8'h00;
            o_p3_pullup_en <= 8'h00;
            o_p3_oe_b <= 8'hFF;
            o_lin_tx_pin <= 1'b1;
            o_lin_tx_oe_b <= 1'b1;
            o_lin_rx <= 1'b1;
        end else begin
            o_sfr_rdata <= rdata_d;
            o_p2_xbar_grant <= grant_d;
            o_p3_pullup_en <= pullup_d;
            o_p3_oe_b <= oe_b_d;
            o_lin_tx_pin <= lin_tx_pin_d;
            o_lin_tx_oe_b <= lin_tx_oe_b_d;
            o_lin_rx <= lin_rx_d;
        end
    end

    // =====================================================
    // port 3 output latch, one flop per pin
    for (genvar n = 0; n < 8; n++) begin : g_p3
        always_ff @(posedge i_clk_sys) begin
            if (!i_rst_b) begin
                o_p3_out[n] <= RST_PORT3_DATA[n] & P3_MASK[n];
            end else begin
                o_p3_out[n] <= cfg_d.port3_data[n];
            end
        end
    end

    // =====================================================
    // external interrupts see port 1 directly, not the crossbar output
    ext_irq_sync u_irq_a (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_pins(i_p1_pin),
        .i_sel(cfg_q.ext_irq_a_pin_select),
        .i_active_high(cfg_q.ext_irq_a_polarity),
        .o_req_q(o_ext_irq_a)
    );

    ext_irq_sync u_irq_b (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_pins(i_p1_pin),
        .i_sel(cfg_q.ext_irq_b_pin_select),
        .i_active_high(cfg_q.ext_irq_b_polarity),
        .o_req_q(o_ext_irq_b)
    );

    // =====================================================
    // checks
    skip_grant_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_ce && i_sfr.wr && sel_skip) |=> ((o_p2_xbar_grant & $past(i_sfr.wdata)) == 8'h00))
        else $error("skipped port 2 pin still granted");

    xbar_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_ce && i_sfr.wr && sel_xbar && !i_sfr.wdata[XBAR_EN_BIT])
        |=> (o_p2_xbar_grant == 8'h00) && o_lin_tx_oe_b)
        else $error("crossbar disabled but pins still routed");

    pullup_ctl_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_ce && i_sfr.wr && sel_xbar)
        |=> o_p3_pullup_en == ($past(i_sfr.wdata[WEAK_PUD_BIT]) ? 8'h00 : (~$past(i_p3_analog) & P3_MASK)))
        else $error("weak pullup state wrong after control write");

    lin_route_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_ce && i_sfr.wr && sel_xbar && !i_sfr.wdata[LIN_ROUTE_BIT]) |=> o_lin_tx_oe_b && o_lin_rx)
        else $error("LIN reached a pin while unrouted");

    p3_latch_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_ce && i_sfr.wr && sel_p3) |=> o_p3_out == ($past(i_sfr.wdata) & P3_MASK))
        else $error("port 3 latch did not take written byte");

    p3_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_ce && i_sfr.rd && sel_p3) |=> o_sfr_rdata == ($past(i_p3_pin) & P3_MASK))
        else $error("port 3 read did not return pin levels");

    p3_bit_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_ce && !i_sfr.wr && i_sfr.bit_wr && sel_p3 && P3_MASK[i_sfr.bit_idx])
        |=> o_p3_out[$past(i_sfr.bit_idx)] == $past(i_sfr.bit_val))
        else $error("port 3 bit write lost");

    p3_narrow_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (o_p3_out & ~P3_MASK) == 8'h00)
        else $error("absent port 3 bit driven");

    irq_a_path_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_ce && !any_wr) [*4]
        |-> o_ext_irq_a == ($past(i_p1_pin[cfg_q.ext_irq_a_pin_select], 3) ~^ cfg_q.ext_irq_a_polarity))
        else $error("first interrupt request does not follow selected pin");

    irq_b_path_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_ce && !any_wr) [*4]
        |-> o_ext_irq_b == ($past(i_p1_pin[cfg_q.ext_irq_b_pin_select], 3) ~^ cfg_q.ext_irq_b_polarity))
        else $error("second interrupt request does not follow selected pin");
endmodule
`default_nettype wire

// ### tb/board_pins.sv
// Purpose: board side of port 1, port 3 and the LIN receive pin
// Assumes: the bench chooses which port 3 pins an outside source drives
// Notes: a released pin with no pullup shows the inverse of the block's last latch value
`timescale 1ns/1ps
`default_nettype none
module board_pins (
    // bench controls
    input wire logic [7:0] i_ext_p1,
    input wire logic [7:0] i_ext_drv,
    input wire logic [7:0] i_ext_val,
    input wire logic i_ext_lin,
    // block side
    input wire logic [7:0] i_p3_out,
    input wire logic [7:0] i_p3_oe_b,
    input wire logic [7:0] i_p3_pullup_en,
    output logic [7:0] o_p1_pin,
    output logic [7:0] o_p3_pin,
    output logic o_lin_rx_pin
);
    // =====================================================
    // pin levels
    // released and unpulled pins never echo the latch, so a stale read cannot pass
    assign o_p1_pin = i_ext_p1;
    assign o_lin_rx_pin = i_ext_lin;
    assign o_p3_pin = (~i_p3_oe_b & i_p3_out) | (i_p3_oe_b & i_ext_drv & i_ext_val)
        | (i_p3_oe_b & ~i_ext_drv & (i_p3_pullup_en | ~i_p3_out));
endmodule
`default_nettype wire

// ### tb/tb_port_crossbar_ext_int_config.sv
// Purpose: self-checking bench for the port crossbar and external irq config block
// Assumes: register reads answer one edge after the request
// Notes: expected read data is queued by the driver and popped by the watcher
`timescale 1ns/1ps
`default_nettype none
module tb_port_crossbar_ext_int_config;
    import port_xbar_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_ce = 1'b1;
    sfr_req_t i_sfr = '0;
    logic [7:0] o_sfr_rdata, i_p1_pin, o_p2_xbar_grant, i_p3_pin, o_p3_out, o_p3_oe_b, o_p3_pullup_en;
    logic [7:0] an = 8'h00, ext_p1 = 8'h00, ext_val = 8'h00, lat, s, v, c;
    logic i_lin_tx = 1'b1, ext_lin = 1'b1, rd_pend = 1'b0;
    logic o_ext_irq_a, o_ext_irq_b, i_lin_rx_pin, o_lin_tx_pin, o_lin_tx_oe_b, o_lin_rx;
    logic [7:0] exp_q[$];
    logic [7:0] rd_small, p3_small;
    int n_errors = 0, checks_done = 0, cycles = 0, seed = 43278;

    port_crossbar_ext_int_config #(.P3_FULL(1'b1)) dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_ce(i_ce), .i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata), .i_p1_pin(i_p1_pin),
        .o_ext_irq_a(o_ext_irq_a), .o_ext_irq_b(o_ext_irq_b), .o_p2_xbar_grant(o_p2_xbar_grant),
        .i_p3_pin(i_p3_pin), .i_p3_analog(an), .o_p3_out(o_p3_out), .o_p3_oe_b(o_p3_oe_b),
        .o_p3_pullup_en(o_p3_pullup_en), .i_lin_tx(i_lin_tx), .i_lin_rx_pin(i_lin_rx_pin),
        .o_lin_tx_pin(o_lin_tx_pin), .o_lin_tx_oe_b(o_lin_tx_oe_b), .o_lin_rx(o_lin_rx));

    // small package variant on the same bus and pins: only port 3 bit 0 exists
    port_crossbar_ext_int_config #(.P3_FULL(1'b0)) dut_small (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_ce(i_ce), .i_sfr(i_sfr), .o_sfr_rdata(rd_small), .i_p1_pin(i_p1_pin), .o_ext_irq_a(),
        .o_ext_irq_b(), .o_p2_xbar_grant(), .i_p3_pin(i_p3_pin), .i_p3_analog(an), .o_p3_out(p3_small),
        .o_p3_oe_b(), .o_p3_pullup_en(), .i_lin_tx(i_lin_tx), .i_lin_rx_pin(i_lin_rx_pin), .o_lin_tx_pin(),
        .o_lin_tx_oe_b(), .o_lin_rx());

    board_pins board (.i_ext_p1(ext_p1), .i_ext_drv(an), .i_ext_val(ext_val), .i_ext_lin(ext_lin),
        .i_p3_out(o_p3_out), .i_p3_oe_b(o_p3_oe_b), .i_p3_pullup_en(o_p3_pullup_en),
        .o_p1_pin(i_p1_pin), .o_p3_pin(i_p3_pin), .o_lin_rx_pin(i_lin_rx_pin));

    always #25 i_clk_sys = ~i_clk_sys;

    // =====================================================
    // compare and report
    task automatic close_out();
        $display("counts: %0d checks, %0d mismatches", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_rd();
        logic [7:0] e;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
        checks_done++;
        if (o_sfr_rdata !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t read got %h exp %h", $time, o_sfr_rdata, e);
        end
    endtask

    // watcher: read data stands one edge after an accepted read; also the hang limit
    always @(posedge i_clk_sys) begin
        if (rd_pend)
            chk_rd();
        rd_pend <= i_sfr.rd && i_ce && i_rst_b;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end

    // =====================================================
    // bus access, request held for one edge then idled
    task automatic bus(input sfr_req_t q, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_sfr <= q;
        if (q.rd)
            exp_q.push_back(e);
        @(posedge i_clk_sys);
        i_sfr <= '0;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] d);
        bus('{addr: a, page: pg, wr: 1'b1, rd: 1'b0, bit_wr: 1'b0, bit_idx: 3'h0, bit_val: 1'b0, wdata: d}, 8'h00);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] e);
        bus('{addr: a, page: pg, wr: 1'b0, rd: 1'b1, bit_wr: 1'b0, bit_idx: 3'h0, bit_val: 1'b0, wdata: 8'h00}, e);
    endtask

    // =====================================================
    // main sequence
    initial begin
        repeat (5) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        // reset values and an unmapped read
        rd(ADDR_EXT_IRQ_CFG, CFG_PAGE, RST_EXT_IRQ_CFG);
        rd(ADDR_XBAR_CTRL2, CFG_PAGE, RST_XBAR_CTRL2);
        rd(ADDR_P2_SKIP, CFG_PAGE, RST_P2_SKIP);
        rd(ADDR_PORT3_DATA, 8'h00, RST_PORT3_DATA);
        rd(8'h80, CFG_PAGE, 8'h00);
        chk_out(o_p3_out, RST_PORT3_DATA, "latch reset");
        chk_out(o_p2_xbar_grant, 8'h00, "grant reset");
        $display("test 1 done");
        // every crossbar mode with a fresh skip mask; reserved bits kept zero
        for (int k = 0; k < 8; k++) begin
            @(posedge i_clk_sys);
            an <= 8'($random(seed));
            i_lin_tx <= k[0];
            ext_lin <= ~k[1];
            s = 8'($random(seed));
            v = {k[2], k[1], 5'h00, k[0]};
            wr(ADDR_P2_SKIP, CFG_PAGE, s);
            wr(ADDR_XBAR_CTRL2, CFG_PAGE, v);
            rd(ADDR_XBAR_CTRL2, CFG_PAGE, v);
            rd(ADDR_P2_SKIP, CFG_PAGE, s);
            chk_out(o_p2_xbar_grant, v[6] ? ~s : 8'h00, "grant");
            chk_out(o_p3_pullup_en, v[7] ? 8'h00 : ~an, "pullup");
            chk_out({5'h00, o_lin_tx_pin, o_lin_tx_oe_b, o_lin_rx},
                (v[6] && v[0]) ? {5'h00, k[0], 1'b0, ~k[1]} : 8'h07, "lin");
        end
        // config write on a foreign page and a write with the clock enable low
        wr(ADDR_XBAR_CTRL2, 8'h00, 8'h00);
        rd(ADDR_XBAR_CTRL2, CFG_PAGE, v);
        @(posedge i_clk_sys);
        i_ce <= 1'b0;
        wr(ADDR_P2_SKIP, CFG_PAGE, ~s);
        @(posedge i_clk_sys);
        i_ce <= 1'b1;
        rd(ADDR_P2_SKIP, CFG_PAGE, s);
        $display("test 2 done");
        // port 3 latch against pin level, analog pins driven from outside
        for (int k = 0; k < 6; k++) begin
            @(posedge i_clk_sys);
            an <= 8'($random(seed));
            ext_val <= 8'($random(seed));
            lat = 8'($random(seed));
            wr(ADDR_PORT3_DATA, 8'($random(seed)), lat);
            chk_out(o_p3_out, lat, "latch");
            chk_out(o_p3_oe_b, an, "drive enable");
            chk_out(p3_small, lat & 8'h01, "narrow latch");
            rd(ADDR_PORT3_DATA, 8'($random(seed)), (lat & ~an) | (ext_val & an));
            chk_out(rd_small, ((lat & ~an) | (ext_val & an)) & 8'h01, "narrow read");
        end
        for (int b = 0; b < 8; b++) begin
            lat[b] = ~lat[b];
            bus('{addr: ADDR_PORT3_DATA, page: 8'(b), wr: 1'b0, rd: 1'b0, bit_wr: 1'b1, bit_idx: 3'(b),
                bit_val: lat[b], wdata: 8'h00}, 8'h00);
            chk_out(o_p3_out, lat, "bit write");
            chk_out(p3_small, lat & 8'h01, "narrow bit write");
        end
        $display("test 3 done");
        // every pin select and polarity for both irqs, crossbar left alone
        for (int k = 0; k < 16; k++) begin
            c = {~k[3], ~3'(k), k[3], 3'(k)};
            wr(ADDR_EXT_IRQ_CFG, CFG_PAGE, c);
            rd(ADDR_EXT_IRQ_CFG, CFG_PAGE, c);
            for (int j = 0; j < 2; j++) begin
                @(posedge i_clk_sys);
                ext_p1 <= 8'($random(seed));
                repeat (4) @(posedge i_clk_sys);
                #1;
                chk_out({7'h00, o_ext_irq_a}, {7'h00, ext_p1[c[2:0]] ~^ c[3]}, "irq a");
                chk_out({7'h00, o_ext_irq_b}, {7'h00, ext_p1[c[6:4]] ~^ c[7]}, "irq b");
                chk_out(o_p2_xbar_grant, ~s, "grant kept");
            end
        end
        $display("test 4 done");
        repeat (3) @(posedge i_clk_sys);
        close_out();
    end
endmodule
`default_nettype wire
